// ### core/acc_ctrl.sv
// register bank and control logic around one analog comparator
// assumes analog core, pads and event system outside; sleep state from power manager
`timescale 1ns/1ps
module acc_ctrl
    import acc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_avs_address,
    input  wire logic       i_avs_read,
    input  wire logic       i_avs_write,
    input  wire logic [7:0] i_avs_writedata,
    output logic      [7:0] o_avs_readdata,
    output logic            o_avs_waitrequest,
    input  wire logic       i_standby,
    input  wire logic       i_power_down,
    input  wire logic       i_clk_per_req,
    input  wire logic       i_cmp_raw,
    output logic            o_cmp_enable,
    output logic            o_low_power_setting,
    output logic      [1:0] o_hysteresis_select,
    output logic            o_positive_input_select,
    output logic      [1:0] o_negative_input_select,
    output logic            o_invert,
    output logic            o_output_pad_enable,
    output logic            o_irq
);
    logic [7:0] ctrl_r;
    logic [7:0] mux_r;
    logic [7:0] ien_r;
    logic       flag_r;
    logic [ACC_SYNC_LEN-1:0] sync_r;
    logic       prev_r;
    logic       ack_r;
    logic       cmp_en_r, pad_en_r, irq_r, wreq_r;
    logic [7:0] rdata_r;

    // power state decoded combinationally; power-down wins over standby
    acc_pm_t pm;
    assign pm = i_power_down ? ACC_PM_PDOWN : (i_standby ? ACC_PM_STANDBY : ACC_PM_ACTIVE);

    // one wait state per access keeps the answer registered
    wire access   = (i_avs_read | i_avs_write);
    wire wr_go    = i_avs_write & ack_r;
    wire wr_ctrl  = wr_go && (i_avs_address == ACC_CTRL_OFS);
    wire wr_mux   = wr_go && (i_avs_address == ACC_MUX_OFS);
    wire wr_ien   = wr_go && (i_avs_address == ACC_IEN_OFS);
    wire wr_stat  = wr_go && (i_avs_address == ACC_STAT_OFS);
    wire clr_flag = wr_stat & i_avs_writedata[ACC_FLAG_BIT];

    wire [1:0] edge_sel = ctrl_r[ACC_EDGE_LSB +: 2];
    wire       cmp_sync = sync_r[ACC_SYNC_LEN-1];
    // clock is gone in standby unless someone else holds it
    wire clk_live = (pm == ACC_PM_ACTIVE) | ((pm == ACC_PM_STANDBY) & i_clk_per_req);
    wire run_ok   = ctrl_r[ACC_EN_BIT] & (pm == ACC_PM_ACTIVE |
                    (pm == ACC_PM_STANDBY & ctrl_r[ACC_RSTB_BIT]));
    wire rise = cmp_sync & ~prev_r;
    wire fall = ~cmp_sync & prev_r;
    wire hit  = (edge_sel == ACC_EDGE_ANY)  ? (rise | fall) :
                (edge_sel == ACC_EDGE_FALL) ? fall :
                (edge_sel == ACC_EDGE_RISE) ? rise : 1'b0;
    wire set_flag = hit & run_ok & clk_live;
    // irq follows the next flag and next enable so a same-cycle enable write is seen
    wire flag_nxt = set_flag | (flag_r & ~clr_flag);
    wire ien_nxt  = wr_ien ? i_avs_writedata[ACC_FLAG_BIT] : ien_r[ACC_FLAG_BIT];

    wire [7:0] stat_v = {3'b000, cmp_sync, 3'b000, flag_r};
    wire [7:0] rd_mux = (i_avs_address == ACC_CTRL_OFS) ? ctrl_r :
                        (i_avs_address == ACC_MUX_OFS)  ? mux_r  :
                        (i_avs_address == ACC_IEN_OFS)  ? ien_r  :
                        (i_avs_address == ACC_STAT_OFS) ? stat_v : 8'h00;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r   <= 1'b0;
            wreq_r  <= 1'b1;
            rdata_r <= ACC_RST_VAL;
        end else begin
            ack_r   <= access & ~ack_r;
            wreq_r  <= ~(access & ~ack_r);
            rdata_r <= (i_avs_read & ~ack_r) ? rd_mux : rdata_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= ACC_RST_VAL;
            mux_r  <= ACC_RST_VAL;
            ien_r  <= ACC_RST_VAL;
        end else begin
            if (wr_ctrl) ctrl_r <= i_avs_writedata & ACC_CTRL_MASK;
            if (wr_mux)  mux_r  <= i_avs_writedata & ACC_MUX_MASK;
            if (wr_ien)  ien_r  <= i_avs_writedata & ACC_IEN_MASK;
        end
    end

    // raw result is asynchronous to the clock; three stages before use
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_r <= '0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[ACC_SYNC_LEN-2:0], i_cmp_raw ^ mux_r[ACC_INV_BIT]};
            prev_r <= clk_live ? cmp_sync : prev_r;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) flag_r <= 1'b0;
        else          flag_r <= flag_nxt;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmp_en_r <= 1'b0;
            pad_en_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            cmp_en_r <= run_ok;
            pad_en_r <= run_ok & ctrl_r[ACC_PAD_BIT];
            irq_r    <= flag_nxt & ien_nxt;
        end
    end

    assign o_avs_readdata          = rdata_r;
    assign o_avs_waitrequest       = wreq_r;
    assign o_cmp_enable            = cmp_en_r;
    assign o_output_pad_enable     = pad_en_r;
    assign o_irq                   = irq_r;
    assign o_low_power_setting     = ctrl_r[ACC_LP_BIT];
    assign o_hysteresis_select     = ctrl_r[ACC_HYS_LSB +: 2];
    assign o_positive_input_select = mux_r[ACC_POS_BIT];
    assign o_negative_input_select = mux_r[ACC_NEG_LSB +: 2];
    assign o_invert                = mux_r[ACC_INV_BIT];

    property p_flag_set;
        @(posedge i_mclk) disable iff (!i_rst_n) set_flag |=> flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on edge");

    property p_flag_clr;
        @(posedge i_mclk) disable iff (!i_rst_n) clr_flag && !set_flag |=> !flag_r;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_zero_keep;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_stat && !i_avs_writedata[0] && flag_r |=> flag_r;
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero write cleared flag");

    property p_irq;
        @(posedge i_mclk) disable iff (!i_rst_n) o_irq == (flag_r & ien_r[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_irq_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
            o_irq && !clr_flag && ien_r[0] && !wr_ien |=> o_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");

    property p_standby;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (pm == ACC_PM_STANDBY) && !i_clk_per_req && !flag_r && !clr_flag |=> !flag_r;
    endproperty
    a_standby: assert property (p_standby) else $error("flag set in standby");

    property p_pdown;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_power_down |=> !o_cmp_enable && !o_output_pad_enable;
    endproperty
    a_pdown: assert property (p_pdown) else $error("active in power-down");

    property p_sync;
        @(posedge i_mclk) disable iff (!i_rst_n)
            ##3 cmp_sync == $past(i_cmp_raw ^ mux_r[7], 3);
    endproperty
    a_sync: assert property (p_sync) else $error("state delay wrong");

    property p_enable;
        @(posedge i_mclk) disable iff (!i_rst_n) !ctrl_r[0] |=> !o_cmp_enable;
    endproperty
    a_enable: assert property (p_enable) else $error("enabled while bit clear");

    property p_wreq_idle;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !i_avs_read && !i_avs_write |=> o_avs_waitrequest;
    endproperty
    a_wreq_idle: assert property (p_wreq_idle) else $error("waitrequest low while idle");

    property p_wreq_one;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wreq_one: assert property (p_wreq_one) else $error("waitrequest low too long");

    property p_wreq_ans;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wreq_ans: assert property (p_wreq_ans) else $error("no answer to request");

    property p_rdata;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_avs_read && o_avs_waitrequest |=> o_avs_readdata == $past(rd_mux);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");

    property p_rd_keep;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("read data moved");

    property p_wr_wait;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_avs_write && o_avs_waitrequest |=> $stable(ctrl_r) && $stable(mux_r) && $stable(ien_r);
    endproperty
    a_wr_wait: assert property (p_wr_wait) else $error("write landed early");

    property p_ctrl_wr;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_ctrl |=> ctrl_r == $past(i_avs_writedata);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_mux_wr;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_mux |=> mux_r == $past(i_avs_writedata & ACC_MUX_MASK);
    endproperty
    a_mux_wr: assert property (p_mux_wr) else $error("select write wrong");

    property p_mux_mask;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (mux_r & ~ACC_MUX_MASK) == 8'h00;
    endproperty
    a_mux_mask: assert property (p_mux_mask) else $error("unused select bit set");

    property p_ien_mask;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (ien_r & ~ACC_IEN_MASK) == 8'h00;
    endproperty
    a_ien_mask: assert property (p_ien_mask) else $error("unused enable bit set");

    property p_ien_wr;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_ien |=> ien_r[ACC_FLAG_BIT] == $past(i_avs_writedata[ACC_FLAG_BIT]);
    endproperty
    a_ien_wr: assert property (p_ien_wr) else $error("irq enable write lost");

    property p_unmapped;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_avs_read && o_avs_waitrequest && (i_avs_address != ACC_CTRL_OFS) &&
            (i_avs_address != ACC_MUX_OFS) && (i_avs_address != ACC_IEN_OFS) &&
            (i_avs_address != ACC_STAT_OFS) |=> o_avs_readdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_stat_rd;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_avs_read && o_avs_waitrequest && (i_avs_address == ACC_STAT_OFS) |=>
            o_avs_readdata[ACC_STATE_BIT] == $past(cmp_sync) &&
            o_avs_readdata[ACC_FLAG_BIT] == $past(flag_r);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

    property p_pad;
        @(posedge i_mclk) disable iff (!i_rst_n)
            o_output_pad_enable |-> o_cmp_enable;
    endproperty
    a_pad: assert property (p_pad) else $error("pad on with comparator off");

    property p_pad_bit;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !ctrl_r[ACC_PAD_BIT] |=> !o_output_pad_enable;
    endproperty
    a_pad_bit: assert property (p_pad_bit) else $error("pad on with bit clear");

    property p_stby_halt;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (pm == ACC_PM_STANDBY) && !ctrl_r[ACC_RSTB_BIT] |=> !o_cmp_enable;
    endproperty
    a_stby_halt: assert property (p_stby_halt) else $error("running in standby");

    property p_stby_run;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (pm == ACC_PM_STANDBY) && ctrl_r[ACC_RSTB_BIT] && ctrl_r[ACC_EN_BIT] |=> o_cmp_enable;
    endproperty
    a_stby_run: assert property (p_stby_run) else $error("halted in standby");

    property p_active_on;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (pm == ACC_PM_ACTIVE) && ctrl_r[ACC_EN_BIT] |=> o_cmp_enable;
    endproperty
    a_active_on: assert property (p_active_on) else $error("not enabled");

    property p_off;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !run_ok |=> !o_cmp_enable && !o_output_pad_enable;
    endproperty
    a_off: assert property (p_off) else $error("event source live while off");

    property p_reserved;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (edge_sel != ACC_EDGE_ANY) && (edge_sel != ACC_EDGE_FALL) &&
            (edge_sel != ACC_EDGE_RISE) |-> !hit;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved edge code hit");

    property p_rise_only;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (edge_sel == ACC_EDGE_RISE) && fall |-> !hit;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("fall hit in rise mode");

    property p_fall_only;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (edge_sel == ACC_EDGE_FALL) && rise |-> !hit;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("rise hit in fall mode");

    property p_noedge;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !rise && !fall && !flag_r |=> !flag_r;
    endproperty
    a_noedge: assert property (p_noedge) else $error("flag set without edge");

    property p_prev_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !clk_live |=> $stable(prev_r);
    endproperty
    a_prev_hold: assert property (p_prev_hold) else $error("edge state moved");

    property p_lp;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_ctrl |=> o_low_power_setting == $past(i_avs_writedata[ACC_LP_BIT]);
    endproperty
    a_lp: assert property (p_lp) else $error("low power output wrong");

    property p_hys;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_ctrl |=> o_hysteresis_select == $past(i_avs_writedata[ACC_HYS_LSB +: 2]);
    endproperty
    a_hys: assert property (p_hys) else $error("hysteresis output wrong");

    property p_pos;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_mux |=> o_positive_input_select == $past(i_avs_writedata[ACC_POS_BIT]);
    endproperty
    a_pos: assert property (p_pos) else $error("positive select wrong");

    property p_neg;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_mux |=> o_negative_input_select == $past(i_avs_writedata[ACC_NEG_LSB +: 2]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative select wrong");

    property p_inv;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_mux |=> o_invert == $past(i_avs_writedata[ACC_INV_BIT]);
    endproperty
    a_inv: assert property (p_inv) else $error("invert output wrong");

    property p_irq_en;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !ien_r[ACC_FLAG_BIT] |-> !o_irq;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while disabled");

    property p_irq_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
            clr_flag && !set_flag |=> !o_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");

    property p_irq_set;
        @(posedge i_mclk) disable iff (!i_rst_n)
            set_flag && ien_r[ACC_FLAG_BIT] && !wr_ien |=> o_irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not raised");

    c_irq:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq));
    c_clr:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) clr_flag && flag_r);
    c_pad:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_output_pad_enable));
    c_stdby: cover property (@(posedge i_mclk) disable iff (!i_rst_n) set_flag && i_standby);
endmodule : acc_ctrl

// ### core/acc_pkg.sv
// constants for the comparator control block
// assumes a 50 MHz peripheral clock and an Avalon-MM slave on the register side
// Summary of operation
// - enable bit turns comparator on
// - run-in-standby keeps comparator alive in standby
// - flag and irq set in standby only while i_clk_per_req is held
// - pad driven only when pad enable set
// - edge field: both, falling, rising; 1 reserved
// - low-power bit selects reduced current
// - hysteresis code: off, 10, 25, 50 mV
// - invert bit flips result for all consumers
// - positive select picks pin zero or one
// - negative select: pin0, pin1, reference, dac
// - irq reaches controller only when enabled
// - state bit via three-cycle synchronizer
// - writing one clears interrupt flag
// - flag set on selected result edge
// - irq high while flag and enable set
// - power-down disables comparator and pad
package acc_pkg;
    localparam logic [2:0] ACC_CTRL_OFS   = 3'h0;
    localparam logic [2:0] ACC_MUX_OFS    = 3'h2;
    localparam logic [2:0] ACC_IEN_OFS    = 3'h6;
    localparam logic [2:0] ACC_STAT_OFS   = 3'h7;
    localparam int         ACC_EN_BIT     = 0;
    localparam int         ACC_HYS_LSB    = 1;
    localparam int         ACC_LP_BIT     = 3;
    localparam int         ACC_EDGE_LSB   = 4;
    localparam int         ACC_PAD_BIT    = 6;
    localparam int         ACC_RSTB_BIT   = 7;
    localparam int         ACC_NEG_LSB    = 0;
    localparam int         ACC_POS_BIT    = 3;
    localparam int         ACC_INV_BIT    = 7;
    localparam int         ACC_FLAG_BIT   = 0;
    localparam int         ACC_STATE_BIT  = 4;
    localparam logic [7:0] ACC_CTRL_MASK  = 8'hFF;
    localparam logic [7:0] ACC_MUX_MASK   = 8'h8B;
    localparam logic [7:0] ACC_IEN_MASK   = 8'h01;
    localparam logic [7:0] ACC_RST_VAL    = 8'h00;
    localparam logic [1:0] ACC_EDGE_ANY   = 2'h0;
    localparam logic [1:0] ACC_EDGE_FALL  = 2'h2;
    localparam logic [1:0] ACC_EDGE_RISE  = 2'h3;
    localparam int         ACC_SYNC_LEN   = 3;
    typedef enum logic [2:0] {
        ACC_PM_ACTIVE  = 3'b001,
        ACC_PM_STANDBY = 3'b010,
        ACC_PM_PDOWN   = 3'b100
    } acc_pm_t;
endpackage : acc_pkg

// ### testbench/acc_cmp_model.sv
// behavioural analog comparator core with its input muxes
// assumes the bench drives pin, reference and dac levels as 8-bit codes
`timescale 1ns/1ps
module acc_cmp_model (
    input  wire logic            i_enable,
    input  wire logic            i_pos_sel,
    input  wire logic [1:0]      i_neg_sel,
    input  wire logic [1:0][7:0] i_pos_lvl,
    input  wire logic [3:0][7:0] i_neg_lvl,
    output logic                 o_raw
);
    logic [7:0] pos_w;
    logic [7:0] neg_w;
    assign pos_w = i_pos_lvl[i_pos_sel];
    assign neg_w = i_neg_lvl[i_neg_sel];
    // a core that is off gives low, not its last result
    assign o_raw = i_enable & (pos_w > neg_w);
endmodule : acc_cmp_model

// ### testbench/analog_comparator_control_tb_top.sv
// self-checking bench for the comparator control block
// assumes the core model drives i_cmp_raw; levels: pin one vs reference
`timescale 1ns/1ps
module analog_comparator_control_tb_top;
    import acc_pkg::*;
    logic mclk = 0, rst_n = 0, rd = 0, wr = 0, stby = 0, pdn = 0, creq = 0;
    logic [2:0] ad = 3'h0;
    logic [7:0] wd = 8'h00, rdata;
    logic wrq, cen, lp, pos, inv, pad, irq, raw;
    logic [1:0] hys, neg;
    logic [1:0][7:0] plvl = '0;
    logic [3:0][7:0] nlvl = {8'h00, 8'h80, 8'h00, 8'h00};
    int err_total = 0, samples_checked = 0;
    always #10 mclk = ~mclk;
    acc_ctrl u_acc_ctrl (.i_mclk(mclk), .i_rst_n(rst_n), .i_avs_address(ad),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wrq), .i_standby(stby),
        .i_power_down(pdn), .i_clk_per_req(creq), .i_cmp_raw(raw), .o_cmp_enable(cen),
        .o_low_power_setting(lp), .o_hysteresis_select(hys), .o_positive_input_select(pos),
        .o_negative_input_select(neg), .o_invert(inv), .o_output_pad_enable(pad), .o_irq(irq));
    acc_cmp_model u_acc_cmp_model (.i_enable(cen), .i_pos_sel(pos), .i_neg_sel(neg),
        .i_pos_lvl(plvl), .i_neg_lvl(nlvl), .o_raw(raw));
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // slave answers after one cycle; still the wait is only bounded by the watchdog
    task bus(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(posedge mclk); while (wrq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task setlvl(input logic [7:0] v);
        @(posedge mclk);
        plvl[1] <= v;
        repeat (6) @(posedge mclk);
    endtask : setlvl
    task t_regs;
        logic [7:0] q;
        logic [2:0] at[5] = '{3'h0, 3'h2, 3'h6, 3'h7, 3'h3};
        logic [7:0] et[5] = '{8'hFF, 8'h8B, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, at[i], 8'h00, q);
            chk("reset", q, 8'h00);
            bus(1'b1, at[i], 8'hFF, q);
            bus(1'b0, at[i], 8'h00, q);
            chk("rw", q, et[i]);
            if (i == 0) chk("ctl", {4'h0, lp, hys, cen}, 8'h0F);
            if (i == 1) chk("mux", {inv, 3'h0, pos, 1'b0, neg}, 8'h8B);
            bus(1'b1, at[i], 8'h00, q);
        end
    endtask : t_regs
    task t_edges;
        logic [7:0] q;
        logic ex;
        bus(1'b1, 3'h2, 8'h0A, q);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 3'h0, {1'b0, m[0], m[1:0], 1'b0, m[1:0], 1'b1}, q);
            bus(1'b1, 3'h6, {7'h00, m[0]}, q);
            chk("pad", {5'h00, pad, hys}, {5'h00, m[0], m[1:0]});
            setlvl(8'hFF);
            bus(1'b0, 3'h7, 8'h00, q);
            ex = (m == 0 || m == 3);
            chk("rise", q, {3'h0, 1'b1, 3'h0, ex});
            chk("irq", {7'h00, irq}, {7'h00, ex & m[0]});
            bus(1'b1, 3'h7, 8'h00, q);
            bus(1'b0, 3'h7, 8'h00, q);
            chk("keep", q, {3'h0, 1'b1, 3'h0, ex});
            bus(1'b1, 3'h7, 8'h01, q);
            setlvl(8'h00);
            bus(1'b0, 3'h7, 8'h00, q);
            chk("fall", q, {7'h00, m == 0 || m == 2});
            bus(1'b1, 3'h7, 8'h01, q);
        end
        bus(1'b1, 3'h2, 8'h8A, q);
        setlvl(8'h00);
        bus(1'b0, 3'h7, 8'h00, q);
        chk("inv", {q[7:1], irq}, 8'h11);
        bus(1'b1, 3'h7, 8'h01, q);
        repeat (2) @(posedge mclk);
        chk("irq_clr", {7'h00, irq}, 8'h00);
    endtask : t_edges
    task t_sleep;
        logic [7:0] q;
        bus(1'b1, 3'h2, 8'h0A, q);
        bus(1'b1, 3'h0, 8'h41, q);
        bus(1'b1, 3'h7, 8'h01, q);
        stby <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("sby_off", {6'h00, pad, cen}, 8'h00);
        bus(1'b1, 3'h0, 8'hC1, q);
        repeat (3) @(posedge mclk);
        chk("sby_on", {6'h00, pad, cen}, 8'h03);
        setlvl(8'hFF);
        bus(1'b0, 3'h7, 8'h00, q);
        chk("sby_flag", q & 8'h01, 8'h00);
        creq <= 1'b1;
        setlvl(8'h00);
        bus(1'b0, 3'h7, 8'h00, q);
        chk("sby_clk", q, 8'h01);
        pdn <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("pdown", {6'h00, pad, cen}, 8'h00);
    endtask : t_sleep
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_edges;
        t_sleep;
        print_verdict;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        print_verdict;
    end
endmodule : analog_comparator_control_tb_top
